// ===== hw/ppfpm_pkg.sv
// constants and types for the parallel port, flag pin and routing pin mux
package ppfpm_pkg;
	localparam int AD_W           = 16;
	localparam int NARROW_W       = 8;
	localparam int ADDR_W         = 24;
	localparam int FLAG_W         = 4;
	localparam int IRQ_N          = 3;
	localparam int ROUTE_PINS     = 20;
	localparam int DEF_ROUTE_SIGS = 16;
	localparam int SYSTEM_CONTROL_REG_W       = 32;
	localparam int EXT_INTERRUPT_IN_0_EN_BIT    = 16;
	localparam int TIMER_OUT_BIT  = 19;
	localparam int PORT_FLAG_BIT  = 20;
	localparam int TIMER_FLAG     = 3;
	localparam int BOOT_SEL_FLAG  = 0;
	localparam int CNT_W          = 4;
	localparam int DEF_ALE_CYC    = 2;
	localparam int DEF_STROBE_CYC = 3;
	localparam logic [AD_W-1:0] AD_ALL_DRIVE  = 16'hffff;
	localparam logic [AD_W-1:0] AD_HIGH_DRIVE = 16'hff00;
	localparam logic [AD_W-1:0] AD_NO_DRIVE   = 16'h0000;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ALE,
		BUS_STROBE,
		BUS_RECOVER
	} ppfpm_bus_e;
endpackage : ppfpm_pkg

// ===== hw/ppfpm_top.sv
// pin mux and strobe logic for shared address/data, flag and routing pins
`timescale 1ns/10ps
`default_nettype none
module ppfpm_top
	import ppfpm_pkg::*;
#(
	parameter int ALE_CYC    = DEF_ALE_CYC,
	parameter int STROBE_CYC = DEF_STROBE_CYC,
	parameter int ROUTE_SIGS = DEF_ROUTE_SIGS,
	parameter int SEL_W      = $clog2(DEF_ROUTE_SIGS)
)
(
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic [SYSTEM_CONTROL_REG_W-1:0]         system_control_reg,
	input  wire logic                        pp_enable,
	input  wire logic                        pp_wide,
	input  wire logic                        ale_active_low,
	input  wire logic                        acc_req,
	input  wire logic                        acc_write,
	input  wire logic [ADDR_W-1:0]           acc_addr,
	input  wire logic [AD_W-1:0]             acc_wdata,
	output var  logic                        acc_ready,
	output var  logic                        acc_done,
	output var  logic [AD_W-1:0]             acc_rdata,
	input  wire logic [AD_W-1:0]             shared_addr_data_pins_in,
	output var  logic [AD_W-1:0]             shared_addr_data_pins_out,
	output var  logic [AD_W-1:0]             shared_addr_data_pins_oe,
	output var  logic                        read_strobe_n,
	output var  logic                        write_strobe_n,
	output var  logic                        addr_latch_strobe,
	input  wire logic [AD_W-1:0]             port_flag_dir,
	input  wire logic [AD_W-1:0]             port_flag_wval,
	output var  logic [AD_W-1:0]             port_flag_level,
	input  wire logic                        capture_sel,
	output var  logic [AD_W-1:0]             capture_data,
	output var  logic                        capture_valid,
	input  wire logic [FLAG_W-1:0]           general_flag_pins_in,
	output var  logic [FLAG_W-1:0]           general_flag_pins_out,
	output var  logic [FLAG_W-1:0]           general_flag_pins_oe,
	input  wire logic [FLAG_W-1:0]           flag_dir,
	input  wire logic [FLAG_W-1:0]           flag_wval,
	output var  logic [FLAG_W-1:0]           flag_level,
	input  wire logic                        spi_master,
	input  wire logic [FLAG_W-1:0]           spi_sel_en,
	input  wire logic [FLAG_W-1:0]           spi_sel_n,
	input  wire logic                        boot_spi_master,
	input  wire logic                        boot_sel_n,
	input  wire logic                        timer_expired,
	output var  logic [IRQ_N-1:0]            irq_req,
	input  wire logic [ROUTE_SIGS-1:0]       route_sig,
	input  wire logic [ROUTE_SIGS-1:0]       route_oe_sig,
	input  wire logic [ROUTE_PINS*SEL_W-1:0] route_sel,
	input  wire logic [ROUTE_PINS*SEL_W-1:0] route_oe_sel,
	input  wire logic [ROUTE_PINS-1:0]       audio_routing_pins_in,
	output var  logic [ROUTE_PINS-1:0]       audio_routing_pins_out,
	output var  logic [ROUTE_PINS-1:0]       audio_routing_pins_oe,
	output var  logic [ROUTE_PINS-1:0]       route_pin_level,
	input  wire logic                        routing_pin_pullup_wr,
	input  wire logic [ROUTE_PINS-1:0]       routing_pin_pullup_ctl,
	output var  logic [ROUTE_PINS-1:0]       pullup_en
);

	////////////////////////////////////////////////////////////////////////////
	if (ALE_CYC < 1 || ALE_CYC >= 2**CNT_W || STROBE_CYC < 1 || STROBE_CYC >= 2**CNT_W)
	begin : g_bad_cyc
		$error("strobe cycle counts out of range");
	end
	if (ROUTE_SIGS < 2 || 2**SEL_W < ROUTE_SIGS)
	begin : g_bad_sel
		$error("route select width too small");
	end

	typedef struct packed {
		ppfpm_bus_e              st;
		logic [CNT_W-1:0]        cnt;
		logic [AD_W-1:0]         last_key;
		logic                    last_valid;
		logic                    last_wide;
		logic                    x_wr;
		logic                    x_wide;
		logic [ADDR_W-1:0]       x_addr;
		logic [AD_W-1:0]         x_data;
		logic                    acc_ready;
		logic                    acc_done;
		logic [AD_W-1:0]         acc_rdata;
		logic [AD_W-1:0]         ad_out;
		logic [AD_W-1:0]         ad_oe;
		logic                    rd_n;
		logic                    wr_n;
		logic                    ale;
		logic [AD_W-1:0]         asy1;
		logic [AD_W-1:0]         asy2;
		logic [AD_W-1:0]         port_flag_level;
		logic [AD_W-1:0]         cap_data;
		logic                    cap_valid;
		logic [FLAG_W-1:0]       fsy1;
		logic [FLAG_W-1:0]       fsy2;
		logic [FLAG_W-1:0]       flag_level;
		logic [FLAG_W-1:0]       flag_out;
		logic [FLAG_W-1:0]       flag_oe;
		logic [IRQ_N-1:0]        irq_req;
		logic [ROUTE_PINS-1:0]   rsy1;
		logic [ROUTE_PINS-1:0]   rsy2;
		logic [ROUTE_PINS-1:0]   route_level;
		logic [ROUTE_PINS-1:0]   rout;
		logic [ROUTE_PINS-1:0]   roe;
		logic [ROUTE_PINS-1:0]   pullup_en;
	} ppfpm_state_s;

	ppfpm_state_s s;
	ppfpm_state_s next_s;
	logic         flag_mode;
	logic         cap_mode;
	logic         bus_mode;
	logic         take;
	logic [AD_W-1:0] req_key;

	function automatic logic ppfpm_pick(input logic [ROUTE_SIGS-1:0] v, input logic [SEL_W-1:0] i);
		return v[i];
	endfunction : ppfpm_pick

	// address bits held by the outside latch for the given width
	function automatic logic [AD_W-1:0] ppfpm_key(input logic [ADDR_W-1:0] a, input logic wide);
		return wide ? a[AD_W-1:0] : a[ADDR_W-1:NARROW_W];
	endfunction : ppfpm_key

	////////////////////////////////////////////////////////////////////////////
	assign flag_mode = system_control_reg[PORT_FLAG_BIT] & ~pp_enable;
	assign cap_mode  = capture_sel & ~flag_mode;
	assign bus_mode  = pp_enable & ~cap_mode;
	assign take      = bus_mode & acc_req & s.acc_ready;
	assign req_key   = ppfpm_key(acc_addr, pp_wide);

	always_comb
	begin
		next_s = s;
		next_s.acc_done  = 1'b0;
		next_s.cap_valid = 1'b0;
		// synchronisers, first stage feeds only the second
		next_s.fsy1 = general_flag_pins_in;
		next_s.fsy2 = s.fsy1;
		next_s.flag_level = s.fsy2;
		next_s.asy1 = shared_addr_data_pins_in;
		next_s.asy2 = s.asy1;
		next_s.port_flag_level = s.asy2;
		next_s.rsy1 = audio_routing_pins_in;
		next_s.rsy2 = s.rsy1;
		next_s.route_level = s.rsy2;
		if (routing_pin_pullup_wr)
		begin
			next_s.pullup_en = routing_pin_pullup_ctl;
		end
		for (int p = 0; p < ROUTE_PINS; p++)
		begin
			next_s.rout[p] = ppfpm_pick(route_sig, route_sel[p*SEL_W +: SEL_W]);
			next_s.roe[p]  = ppfpm_pick(route_oe_sig, route_oe_sel[p*SEL_W +: SEL_W]);
		end
		// general flags, later assignments win
		for (int i = 0; i < FLAG_W; i++)
		begin
			next_s.flag_oe[i]  = flag_dir[i];
			next_s.flag_out[i] = flag_wval[i];
			if (spi_master && spi_sel_en[i])
			begin
				next_s.flag_oe[i]  = 1'b1;
				next_s.flag_out[i] = spi_sel_n[i];
			end
			if (i == TIMER_FLAG && system_control_reg[TIMER_OUT_BIT])
			begin
				next_s.flag_oe[i]  = 1'b1;
				next_s.flag_out[i] = timer_expired;
			end
			if (i < IRQ_N && system_control_reg[EXT_INTERRUPT_IN_0_EN_BIT+i])
			begin
				next_s.flag_oe[i] = 1'b0;
			end
			if (i == BOOT_SEL_FLAG && boot_spi_master)
			begin
				next_s.flag_oe[i]  = 1'b1;
				next_s.flag_out[i] = boot_sel_n;
			end
		end
		// interrupt pins are active low, synchronised before use
		for (int i = 0; i < IRQ_N; i++)
		begin
			next_s.irq_req[i] = system_control_reg[EXT_INTERRUPT_IN_0_EN_BIT+i] & ~s.fsy2[i];
		end
		// external bus sequencer
		if (!bus_mode)
		begin
			next_s.st = BUS_IDLE;
			next_s.last_valid = 1'b0;
		end
		else
		begin
			case (s.st)
				BUS_IDLE:
				begin
					if (take)
					begin
						next_s.x_wr   = acc_write;
						next_s.x_wide = pp_wide;
						next_s.x_addr = acc_addr;
						next_s.x_data = acc_wdata;
						next_s.cnt    = '0;
						if (s.last_valid && s.last_wide == pp_wide && s.last_key == req_key)
						begin
							next_s.st = BUS_STROBE;
						end
						else
						begin
							next_s.st = BUS_ALE;
							next_s.last_key   = req_key;
							next_s.last_valid = 1'b1;
							next_s.last_wide  = pp_wide;
						end
					end
				end
				BUS_ALE:
				begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CNT_W'(ALE_CYC - 1))
					begin
						next_s.st  = BUS_STROBE;
						next_s.cnt = '0;
					end
				end
				BUS_STROBE:
				begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CNT_W'(STROBE_CYC - 1))
					begin
						next_s.st = BUS_RECOVER;
						next_s.acc_done = 1'b1;
						if (!s.x_wr)
						begin
							next_s.acc_rdata = s.x_wide ? shared_addr_data_pins_in :
								{{NARROW_W{1'b0}}, shared_addr_data_pins_in[NARROW_W-1:0]};
						end
					end
				end
				BUS_RECOVER:
				begin
					next_s.st = BUS_IDLE;
				end
				default:
				begin
					next_s.st = BUS_IDLE;
				end
			endcase
		end
		next_s.acc_ready = bus_mode && next_s.st == BUS_IDLE;
		// strobes follow the next state; all idle in flag use
		next_s.rd_n = !(next_s.st == BUS_STROBE && !next_s.x_wr);
		next_s.wr_n = !(next_s.st == BUS_STROBE && next_s.x_wr);
		next_s.ale  = (next_s.st == BUS_ALE) ^ ale_active_low;
		// shared pin drive
		next_s.ad_out = AD_NO_DRIVE;
		next_s.ad_oe  = AD_NO_DRIVE;
		if (flag_mode)
		begin
			next_s.ad_out = port_flag_wval;
			next_s.ad_oe  = port_flag_dir;
		end
		else if (cap_mode)
		begin
			next_s.cap_data  = shared_addr_data_pins_in;
			next_s.cap_valid = 1'b1;
		end
		else if (next_s.st == BUS_ALE)
		begin
			next_s.ad_out = ppfpm_key(next_s.x_addr, next_s.x_wide);
			next_s.ad_oe  = AD_ALL_DRIVE;
		end
		else if (next_s.st == BUS_STROBE)
		begin
			// narrow width carries address bits 7..0 on the upper byte lane
			if (next_s.x_wide)
			begin
				next_s.ad_out = next_s.x_data;
				next_s.ad_oe  = next_s.x_wr ? AD_ALL_DRIVE : AD_NO_DRIVE;
			end
			else
			begin
				next_s.ad_out = {next_s.x_addr[NARROW_W-1:0], next_s.x_data[NARROW_W-1:0]};
				next_s.ad_oe  = next_s.x_wr ? AD_ALL_DRIVE : AD_HIGH_DRIVE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s           <= '0;
			s.rd_n      <= 1'b1;
			s.wr_n      <= 1'b1;
			s.pullup_en <= '1;
		end
		else
		begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign acc_ready                 = s.acc_ready;
	assign acc_done                  = s.acc_done;
	assign acc_rdata                 = s.acc_rdata;
	assign shared_addr_data_pins_out = s.ad_out;
	assign shared_addr_data_pins_oe  = s.ad_oe;
	assign read_strobe_n             = s.rd_n;
	assign write_strobe_n            = s.wr_n;
	assign addr_latch_strobe         = s.ale;
	assign port_flag_level           = s.port_flag_level;
	assign capture_data              = s.cap_data;
	assign capture_valid             = s.cap_valid;
	assign general_flag_pins_out     = s.flag_out;
	assign general_flag_pins_oe      = s.flag_oe;
	assign flag_level                = s.flag_level;
	assign irq_req                   = s.irq_req;
	assign audio_routing_pins_out    = s.rout;
	assign audio_routing_pins_oe     = s.roe;
	assign route_pin_level           = s.route_level;
	assign pullup_en                 = s.pullup_en;

	////////////////////////////////////////////////////////////////////////////
	localparam int STB_MAX = 20;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence take_new_addr;
		take && !(s.last_valid && s.last_wide == pp_wide && s.last_key == req_key);
	endsequence
	sequence take_read;
		take && !acc_write;
	endsequence
	sequence take_write;
		take && acc_write;
	endsequence

	a_narrow_ale_pulse: assert property (take_new_addr and !pp_wide |=>
		addr_latch_strobe != ale_active_low && shared_addr_data_pins_out == $past(acc_addr[ADDR_W-1:NARROW_W]))
		else $error("narrow latch strobe missing on new upper address");
	a_wide_ale_pulse: assert property (take_new_addr and pp_wide |=>
		addr_latch_strobe != ale_active_low && shared_addr_data_pins_out == $past(acc_addr[AD_W-1:0]))
		else $error("wide latch strobe missing on new low address");
	a_ale_marks_addr: assert property (addr_latch_strobe != $past(ale_active_low) |->
		shared_addr_data_pins_oe == AD_ALL_DRIVE && read_strobe_n && write_strobe_n)
		else $error("latch strobe without address on pins");
	a_ale_polarity: assert property (addr_latch_strobe == ((s.st == BUS_ALE) ^ $past(ale_active_low)))
		else $error("latch strobe polarity wrong");
	a_read_strobe_low: assert property (take_read |-> ##[1:STB_MAX] !read_strobe_n)
		else $error("read strobe never asserted");
	a_write_strobe_low: assert property (take_write |-> ##[1:STB_MAX] !write_strobe_n)
		else $error("write strobe never asserted");
	a_flag_strobes_idle: assert property (flag_mode |=>
		read_strobe_n && write_strobe_n && addr_latch_strobe == $past(ale_active_low))
		else $error("strobe active in flag use");
	a_port_flag_drive: assert property (flag_mode |=> shared_addr_data_pins_oe == $past(port_flag_dir))
		else $error("shared pins not following flag direction");
	a_flag_gpio_out: assert property (!spi_master && !boot_spi_master && !system_control_reg[EXT_INTERRUPT_IN_0_EN_BIT+1]
		|=> general_flag_pins_oe[1] == $past(flag_dir[1]) && general_flag_pins_out[1] == $past(flag_wval[1]))
		else $error("flag 1 not following software");
	a_spi_select: assert property (spi_master && spi_sel_en[2] && !system_control_reg[EXT_INTERRUPT_IN_0_EN_BIT+2]
		|=> general_flag_pins_oe[2] && general_flag_pins_out[2] == $past(spi_sel_n[2]))
		else $error("slave select not on flag 2");
	a_boot_select: assert property (boot_spi_master |=>
		general_flag_pins_oe[0] && general_flag_pins_out[0] == $past(boot_sel_n))
		else $error("boot slave select not on flag 0");
	a_irq_synced: assert property (irq_req[0] |-> $past(general_flag_pins_in[0], 3) == 1'b0)
		else $error("interrupt raised without synchronised low");
	a_timer_out: assert property (system_control_reg[TIMER_OUT_BIT] |=>
		general_flag_pins_oe[TIMER_FLAG] && general_flag_pins_out[TIMER_FLAG] == $past(timer_expired))
		else $error("timer expiry not on flag 3");
	a_capture_path: assert property (cap_mode |=> capture_valid && capture_data == $past(shared_addr_data_pins_in))
		else $error("capture data not taken from shared pins");
	a_route_pin0: assert property (##1 audio_routing_pins_out[0] == $past(route_sig[route_sel[SEL_W-1:0]]))
		else $error("routing pin 0 output mismatch");
	a_pullup_write: assert property (routing_pin_pullup_wr |=> pullup_en == $past(routing_pin_pullup_ctl))
		else $error("pull-up control not taken");

endmodule : ppfpm_top
`default_nettype wire

// ===== verif/ppfpm_mem.sv
// external memory with its address latch, on the shared address/data pins
`timescale 1ns/10ps
`default_nettype none
module ppfpm_mem
	import ppfpm_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic [AD_W-1:0] pins,
	input  wire logic            ale,
	input  wire logic            ale_active_low,
	input  wire logic            rd_n,
	input  wire logic            wr_n,
	input  wire logic            wide,
	output var  logic [AD_W-1:0] mem_out,
	output var  logic [AD_W-1:0] mem_oe
);
	logic [AD_W-1:0]   lat;
	logic [ADDR_W-1:0] addr;
	logic [AD_W-1:0]   mem [int];

	// latch captures the pins while the strobe is asserted
	always @(posedge sys_clk)
		if (ale != ale_active_low)
			lat = pins;
	// 8-bit: latch holds the high address, low byte rides on pins 15..8
	assign addr = wide ? {8'h00, lat} : {lat, pins[15:8]};
	always @(posedge sys_clk)
		if (!wr_n)
			mem[int'(addr)] = wide ? pins : {8'h00, pins[7:0]};
	// read data only while read strobe low, else released to pull-ups
	assign mem_oe = rd_n ? 16'h0000 : (wide ? 16'hffff : 16'h00ff);
	// refreshed each falling edge so a word written earlier is seen on a later read
	always @(negedge sys_clk)
		mem_out <= mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hdead;
endmodule : ppfpm_mem
`default_nettype wire

// ===== verif/tb_parallel_port_flag_pin_mux.sv
// testbench for the parallel port, flag pin and routing pin mux
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_port_flag_pin_mux
	import ppfpm_pkg::*;
;
	localparam int ALE_N = 2;
	localparam int STR_N = 3;
	typedef struct packed {
		logic              wide;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [AD_W-1:0]   wdata;
		logic [3:0]        ale;
		logic [AD_W-1:0]   rdata;
	} ppfpm_row_s;

	logic sys_clk = 0, rst_n = 0, pp_enable = 1, pp_wide = 1, ale_active_low = 0, acc_req = 0;
	logic acc_write = 0, capture_sel = 0, spi_master = 0, boot_spi_master = 0, boot_sel_n = 1;
	logic timer_expired = 0, routing_pin_pullup_wr = 0;
	logic acc_ready, acc_done, read_strobe_n, write_strobe_n, addr_latch_strobe, capture_valid;
	logic [SYSTEM_CONTROL_REG_W-1:0]     system_control_reg = 0;
	logic [ADDR_W-1:0]       acc_addr = 0;
	logic [AD_W-1:0]         acc_wdata = 0, port_flag_dir = 0, port_flag_wval = 0;
	logic [AD_W-1:0]         tb_val = 0, tb_mask = 0;
	logic [AD_W-1:0]         acc_rdata, port_flag_level, capture_data, m_out, m_oe;
	logic [AD_W-1:0]         shared_addr_data_pins_in, shared_addr_data_pins_out;
	logic [AD_W-1:0]         shared_addr_data_pins_oe;
	logic [FLAG_W-1:0]       flag_dir = 0, flag_wval = 0, spi_sel_en = 0, spi_sel_n = 4'hf;
	logic [FLAG_W-1:0]       g_tb = 4'hf;
	logic [FLAG_W-1:0]       general_flag_pins_in, general_flag_pins_out, general_flag_pins_oe;
	logic [FLAG_W-1:0]       flag_level;
	logic [IRQ_N-1:0]        irq_req;
	logic [15:0]             route_sig = 0, route_oe_sig = 0;
	logic [ROUTE_PINS*4-1:0] route_sel = 0, route_oe_sel = 0;
	logic [ROUTE_PINS-1:0]   routing_pin_pullup_ctl = 0;
	logic [ROUTE_PINS-1:0]   audio_routing_pins_in, audio_routing_pins_out;
	logic [ROUTE_PINS-1:0]   audio_routing_pins_oe, route_pin_level, pullup_en;
	int                      n_mismatch = 0, compares = 0, cyc = 0;
	ppfpm_row_s              rows [9] = '{
		'{1'b1, 1'b1, 24'h00_0010, 16'h1234, 4'd2, 16'h0000},
		'{1'b1, 1'b0, 24'h00_0010, 16'h0000, 4'd0, 16'h1234},
		'{1'b0, 1'b1, 24'h00_1234, 16'h00ab, 4'd2, 16'h0000},
		'{1'b0, 1'b1, 24'h00_1235, 16'h00cd, 4'd0, 16'h0000},
		'{1'b0, 1'b0, 24'h00_1234, 16'h0000, 4'd0, 16'h00ab},
		'{1'b0, 1'b1, 24'h01_1235, 16'h0077, 4'd2, 16'h0000},
		'{1'b0, 1'b0, 24'h01_1235, 16'h0000, 4'd0, 16'h0077},
		'{1'b0, 1'b0, 24'h00_1235, 16'h0000, 4'd2, 16'h00cd},
		'{1'b1, 1'b0, 24'h00_0010, 16'h0000, 4'd2, 16'h1234}};

	// pins: design, then memory, then bench, else pull-up
	assign shared_addr_data_pins_in = (shared_addr_data_pins_oe & shared_addr_data_pins_out)
		| (~shared_addr_data_pins_oe & m_oe & m_out)
		| (~shared_addr_data_pins_oe & ~m_oe & (tb_val | ~tb_mask));
	assign general_flag_pins_in = (general_flag_pins_oe & general_flag_pins_out)
		| (~general_flag_pins_oe & g_tb);
	assign audio_routing_pins_in = audio_routing_pins_oe & audio_routing_pins_out
		| ~audio_routing_pins_oe;

	ppfpm_top #(.ALE_CYC(ALE_N), .STROBE_CYC(STR_N)) uut (.*);
	ppfpm_mem mem (.sys_clk(sys_clk), .pins(shared_addr_data_pins_in), .ale(addr_latch_strobe),
		.ale_active_low(ale_active_low), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
		.wide(pp_wide), .mem_out(m_out), .mem_oe(m_oe));

	always #2.5 sys_clk = ~sys_clk;

	//////////////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_n

	// one bus transfer, counting strobe cycles until done
	task automatic do_acc(input ppfpm_row_s r);
		int t;
		int na;
		int ns;
		t = 0;
		na = 0;
		ns = 0;
		pp_wide = r.wide;
		acc_write = r.wr;
		acc_addr = r.addr;
		acc_wdata = r.wdata;
		acc_req = 1;
		while (acc_ready !== 1'b1 && t < 20)
		begin
			@(negedge sys_clk);
			t++;
		end
		@(negedge sys_clk);
		acc_req = 0;
		t = 0;
		while (acc_done !== 1'b1 && t < 40)
		begin
			na += (addr_latch_strobe === 1'b1);
			ns += ((r.wr ? write_strobe_n : read_strobe_n) === 1'b0);
			t++;
			@(negedge sys_clk);
		end
		chk("latency", STR_N + r.ale, t);
		chk("latch_cycles", r.ale, na);
		chk("strobe_cycles", STR_N, ns);
		if (!r.wr)
			chk("rdata", r.rdata, acc_rdata);
		@(negedge sys_clk);
	endtask : do_acc

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#20;
		chk("reset_strobes", 3'b110, {read_strobe_n, write_strobe_n, addr_latch_strobe});
		chk("reset_pullups", 20'hf_ffff, pullup_en);
		wait_n(8);
		rst_n = 1;
		wait_n(2);
		foreach (rows[i])
			do_acc(rows[i]);
		$display("test bus done");
		// flag use of the shared pins, with a request left pending
		pp_enable = 0;
		system_control_reg = 32'h0010_0000;
		port_flag_dir = 16'h00ff;
		port_flag_wval = 16'ha5a5;
		acc_req = 1;
		wait_n(5);
		chk("pf_oe", 16'h00ff, shared_addr_data_pins_oe);
		chk("pf_out", 16'h00a5, shared_addr_data_pins_out & 16'h00ff);
		chk("pf_level", 16'hffa5, port_flag_level);
		chk("pf_strobes", 4'b1100, {read_strobe_n, write_strobe_n, addr_latch_strobe, acc_ready});
		acc_req = 0;
		system_control_reg = 0;
		pp_enable = 1;
		capture_sel = 1;
		tb_mask = 16'hffff;
		tb_val = 16'h5a3c;
		wait_n(3);
		chk("capture", 18'h1_5a3c, {acc_ready, capture_valid, capture_data});
		capture_sel = 0;
		tb_mask = 0;
		ale_active_low = 1;
		wait_n(3);
		chk("ale_idle_low", 1, addr_latch_strobe);
		ale_active_low = 0;
		$display("test pin modes done");
		flag_dir = 4'b0101;
		flag_wval = 4'b0001;
		g_tb = 4'b1010;
		wait_n(5);
		chk("gf_drive", 8'h51, {general_flag_pins_oe, general_flag_pins_out & 4'b0101});
		chk("gf_level", 4'b1011, flag_level);
		for (int k = 0; k < 3; k++)
		begin
			system_control_reg = 32'h1 << (EXT_INTERRUPT_IN_0_EN_BIT + k);
			g_tb = ~(4'h1 << k);
			wait_n(5);
			chk("irq", 32'h1 << k, irq_req);
			chk("irq_oe", 0, general_flag_pins_oe[k]);
		end
		system_control_reg = 32'h0008_0000;
		timer_expired = 1;
		wait_n(3);
		chk("timer", 2'b11, {general_flag_pins_oe[3], general_flag_pins_out[3]});
		system_control_reg = 0;
		spi_master = 1;
		spi_sel_en = 4'b0110;
		spi_sel_n = 4'b0000;
		wait_n(3);
		chk("spi_sel", 2'b10, {general_flag_pins_oe[1], general_flag_pins_out[1]});
		chk("spi_sel2", 2'b10, {general_flag_pins_oe[2], general_flag_pins_out[2]});
		system_control_reg = 32'h0001_0000;
		boot_spi_master = 1;
		boot_sel_n = 0;
		wait_n(3);
		chk("boot_sel", 2'b10, {general_flag_pins_oe[0], general_flag_pins_out[0]});
		$display("test flags done");
		route_sig = 16'h0020;
		route_oe_sig = 16'h0004;
		route_sel = {20{4'd5}};
		route_oe_sel = {20{4'd2}};
		wait_n(3);
		chk("route_oe", 20'hf_ffff, audio_routing_pins_oe);
		chk("route_out", 20'hf_ffff, audio_routing_pins_out);
		route_sel[3:0] = 4'd0;
		wait_n(5);
		chk("route_out0", 20'hf_fffe, audio_routing_pins_out);
		chk("route_level", 20'hf_fffe, route_pin_level);
		routing_pin_pullup_ctl = 20'h0_0f0f;
		routing_pin_pullup_wr = 1;
		wait_n(1);
		routing_pin_pullup_wr = 0;
		wait_n(2);
		chk("pullups", 20'h0_0f0f, pullup_en);
		$display("test routing done");
		end_sim();
	end
endmodule : tb_parallel_port_flag_pin_mux
`default_nettype wire
